// ### hdl/dcc_top.sv
// design: two comparator control registers with result sync and change interrupts
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// (R1) Two comparator channels each have their own control register of identical layout.
// (R2) Bit 7 set hands the input pins to the comparator, clear keeps them as I/O.
// (R3) Bit 6 powers the comparator on when set and off when clear.
// (R4) Bit 5 set inverts the comparator result seen in the status bit.
// (R5) Bit 4 is read-only and shows the polarity-adjusted result of plus above minus.
// (R6) The output pin is driven only when bit 3 is clear and bit 7 is set.
// (R7) Bits 2 and 1 read as zero and ignore writes.
// (R8) Bit 0 turns the comparator hysteresis on when set.
// (R9) Pull-high resistors on the input pins are cut while the comparator owns them.
// (R10) A change of a result bit sets that channel's flag, which also wakes the device while that channel is powered.
// (R11) While the comparator owns the pins, I/O reads give zero for inputs, data for outputs.
// (R12) The raw comparator result is synchronised before it updates the result bit.
module dcc_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [4:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]     wb_dat_o,
    output logic            wb_ack_o,
    input  wire logic [1:0] cmp_raw,
    input  wire logic [1:0] port_dir_in,
    input  wire logic [1:0] port_data,
    output logic [1:0]      cmp_pin_select,
    output logic [1:0]      cmp_power_on,
    output logic [1:0]      cmp_hysteresis_on,
    output logic [1:0]      cmp_pullup_cut,
    output logic [1:0]      cmp_output_pin,
    output logic [1:0]      cmp_output_pin_oe,
    output logic [1:0]      io_read_value,
    output logic [1:0]      io_read_override,
    output logic [1:0]      wake,
    output logic            irq
);
    import dcc_pkg::*;

    logic [7:0]  ctrl_rd0;
    logic [7:0]  ctrl_rd1;
    logic [1:0]  ctrl_wr;
    logic [1:0]  result;
    logic [1:0]  change;
    logic [1:0]  status;
    logic [1:0]  next_status;
    logic [1:0]  enable;
    logic [1:0]  next_enable;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        req;
    logic        wr_lane0;
    logic        hit_ctrl0;
    logic        hit_ctrl1;
    logic        hit_status;
    logic        hit_enable;
    logic        hit_clear;

    // a new request each cycle only while no ack is standing
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

    // decode; only the clear register sits above the low offsets
    assign hit_ctrl0  = wb_adr_i == {1'b0, DCC_ADDR_CTRL0};
    assign hit_ctrl1  = wb_adr_i == {1'b0, DCC_ADDR_CTRL1};
    assign hit_status = wb_adr_i == {1'b0, DCC_ADDR_STATUS};
    assign hit_enable = wb_adr_i == {1'b0, DCC_ADDR_ENABLE};
    assign hit_clear  = wb_adr_i == DCC_ADDR_CLEAR;
    assign ctrl_wr[0] = wr_lane0 && hit_ctrl0; // [R1]
    assign ctrl_wr[1] = wr_lane0 && hit_ctrl1; // [R1]

    // channel 0
    dcc_channel #(
        .CTRL_RESET       (DCC_CTRL_RESET)
    ) u_ch0 (
        .clk              (clk),
        .rst              (rst),
        .ctrl_wr          (ctrl_wr[0]),
        .ctrl_wdata       (wb_dat_i[7:0]),
        .raw              (cmp_raw[0]),
        .port_dir_in      (port_dir_in[0]),
        .port_data        (port_data[0]),
        .ctrl_rdata       (ctrl_rd0),
        .result           (result[0]),
        .change           (change[0]),
        .pin_select       (cmp_pin_select[0]),
        .power_on         (cmp_power_on[0]),
        .hysteresis_on    (cmp_hysteresis_on[0]),
        .pullup_cut       (cmp_pullup_cut[0]),
        .output_pin       (cmp_output_pin[0]),
        .output_pin_oe    (cmp_output_pin_oe[0]),
        .io_read_value    (io_read_value[0]),
        .io_read_override (io_read_override[0])
    );

    // channel 1: same hardware and layout, its own register
    dcc_channel #(
        .CTRL_RESET       (DCC_CTRL_RESET)
    ) u_ch1 (
        .clk              (clk),
        .rst              (rst),
        .ctrl_wr          (ctrl_wr[1]),
        .ctrl_wdata       (wb_dat_i[7:0]),
        .raw              (cmp_raw[1]),
        .port_dir_in      (port_dir_in[1]),
        .port_data        (port_data[1]),
        .ctrl_rdata       (ctrl_rd1),
        .result           (result[1]),
        .change           (change[1]),
        .pin_select       (cmp_pin_select[1]),
        .power_on         (cmp_power_on[1]),
        .hysteresis_on    (cmp_hysteresis_on[1]),
        .pullup_cut       (cmp_pullup_cut[1]),
        .output_pin       (cmp_output_pin[1]),
        .output_pin_oe    (cmp_output_pin_oe[1]),
        .io_read_value    (io_read_value[1]),
        .io_read_override (io_read_override[1])
    );

    // sticky flags: a new change wins over a clear in the same cycle
    always_comb begin
        next_status = status;
        if (wr_lane0 && hit_clear) begin
            next_status = status & ~wb_dat_i[1:0];
        end
        next_status = next_status | change; // [R10]
    end

    // flag register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= DCC_IRQ_RESET;
        end else begin
            status <= next_status;
        end
    end

    // interrupt enable, written whole
    always_comb begin
        next_enable = enable;
        if (wr_lane0 && hit_enable) begin
            next_enable = wb_dat_i[1:0];
        end
    end

    // enable register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable <= DCC_IRQ_RESET;
        end else begin
            enable <= next_enable;
        end
    end

    // one-cycle ack; the standing ack blocks a second take of one request
    always_comb begin
        next_ack = req;
    end

    // ack flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= next_ack;
        end
    end

    // read mux; unmapped offsets and the clear register read zero
    always_comb begin
        next_dat = 32'h0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                {1'b0, DCC_ADDR_CTRL0}:  next_dat[7:0] = ctrl_rd0; // [R5]
                {1'b0, DCC_ADDR_CTRL1}:  next_dat[7:0] = ctrl_rd1; // [R5]
                {1'b0, DCC_ADDR_STATUS}: next_dat[1:0] = status;
                {1'b0, DCC_ADDR_ENABLE}: next_dat[1:0] = enable;
                default:                 next_dat = 32'h0;
            endcase
        end
    end

    // read data flop; zero outside a read so stale data never lingers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= next_dat;
        end
    end

    // wake follows the flag of a powered channel; irq gated by enable
    assign wake = status & cmp_power_on; // [R10]
    assign irq  = |(status & enable);
endmodule

// one channel: control register, synchronised result and pin controls
module dcc_channel #(
    parameter logic [7:0] CTRL_RESET = dcc_pkg::DCC_CTRL_RESET
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ctrl_wr,
    input  wire logic [7:0] ctrl_wdata,
    input  wire logic       raw,
    input  wire logic       port_dir_in,
    input  wire logic       port_data,
    output logic [7:0]      ctrl_rdata,
    output logic            result,
    output logic            change,
    output logic            pin_select,
    output logic            power_on,
    output logic            hysteresis_on,
    output logic            pullup_cut,
    output logic            output_pin,
    output logic            output_pin_oe,
    output logic            io_read_value,
    output logic            io_read_override
);
    import dcc_pkg::*;

    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic       sync_a;
    logic       next_sync_a;
    logic       sync_b;
    logic       next_sync_b;
    logic       next_result;

    // synchroniser next values; only sync_b is read beyond this pair
    always_comb begin
        next_sync_a = raw; // [R12]
        next_sync_b = sync_a; // [R12]
    end

    // two flops, so a metastable first stage never reaches the flag logic
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // write keeps only the writable bits; bits 4, 2 and 1 stay zero in storage
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_wr) begin
            next_ctrl = ctrl_wdata & DCC_CTRL_WMASK; // [R1] [R7]
        end
    end

    // control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // polarity after sync; a powered-off comparator reads low
    always_comb begin
        next_result = ctrl[DCC_BIT_PWR] & (sync_b ^ ctrl[DCC_BIT_INV]); // [R4] [R5]
    end

    // result flop; a polarity or power write also moves it and sets the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result <= 1'b0;
        end else begin
            result <= next_result;
        end
    end

    // high in the cycle before the result flop takes a new value
    assign change = result ^ next_result; // [R10]

    // read-back: the live result stands in place of stored bit 4
    assign ctrl_rdata = ctrl | {3'h0, result, 4'h0}; // [R5] [R7]

    // pin and analog controls
    assign pin_select       = ctrl[DCC_BIT_SEL]; // [R2]
    assign power_on         = ctrl[DCC_BIT_PWR]; // [R3]
    assign hysteresis_on    = ctrl[DCC_BIT_HYS]; // [R8]
    assign pullup_cut       = ctrl[DCC_BIT_SEL]; // [R9]
    // pin stays I/O unless the comparator owns it and bit 3 is clear
    assign output_pin_oe    = ctrl[DCC_BIT_SEL] & ~ctrl[DCC_BIT_INT]; // [R6]
    assign output_pin       = result; // [R6]
    // I/O read path while the comparator owns the pins
    assign io_read_override = ctrl[DCC_BIT_SEL]; // [R11]
    assign io_read_value    = port_dir_in ? 1'b0 : port_data; // [R11]
endmodule
`default_nettype wire

// ### hdl/dcc_pkg.sv
// package: register map, field positions and reset values of the comparator control block
package dcc_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] DCC_ADDR_CTRL0   = 4'h0;
    localparam logic [3:0] DCC_ADDR_CTRL1   = 4'h4;
    localparam logic [3:0] DCC_ADDR_STATUS  = 4'h8;
    localparam logic [3:0] DCC_ADDR_ENABLE  = 4'hC;
    // the clear register alone sits in the upper half of the map
    localparam logic [4:0] DCC_ADDR_CLEAR   = 5'h10;
    // control field positions
    localparam int DCC_BIT_SEL   = 7;
    localparam int DCC_BIT_PWR   = 6;
    localparam int DCC_BIT_INV   = 5;
    localparam int DCC_BIT_RES   = 4;
    localparam int DCC_BIT_INT   = 3;
    localparam int DCC_BIT_HYS   = 0;
    // writable bits of a control register
    localparam logic [7:0] DCC_CTRL_WMASK = 8'hE9;
    localparam logic [7:0] DCC_CTRL_RESET = 8'h81;
    localparam logic [1:0] DCC_IRQ_RESET  = 2'h0;
endpackage

// ### bench/dcc_top_asserts.sv
// checker: bus handshake and pin routing relations of the control block
`timescale 1ns/1ns
`default_nettype none
module dcc_top_asserts (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [1:0] port_dir_in,
    input wire logic [1:0] port_data,
    input wire logic [1:0] cmp_pin_select,
    input wire logic [1:0] cmp_power_on,
    input wire logic [1:0] cmp_pullup_cut,
    input wire logic [1:0] cmp_output_pin_oe,
    input wire logic [1:0] io_read_value,
    input wire logic [1:0] io_read_override,
    input wire logic [1:0] wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    property p_oe; (cmp_output_pin_oe & ~cmp_pin_select) == 2'h0; endproperty
    a_oe: assert property (p_oe) else $error("pin driven while io");
    property p_cut; cmp_pullup_cut == cmp_pin_select; endproperty
    a_cut: assert property (p_cut) else $error("pull-up cut wrong");
    property p_ovr; io_read_override == cmp_pin_select; endproperty
    a_ovr: assert property (p_ovr) else $error("override wrong");
    property p_val; (io_read_value & io_read_override) ==
        (~port_dir_in & port_data & io_read_override); endproperty
    a_val: assert property (p_val) else $error("io read value wrong");
    property p_wake; (wake & ~cmp_power_on) == 2'h0; endproperty
    a_wake: assert property (p_wake) else $error("wake while off");
endmodule
bind dcc_top dcc_top_asserts u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .port_dir_in(port_dir_in),
    .port_data(port_data), .cmp_pin_select(cmp_pin_select), .cmp_power_on(cmp_power_on),
    .cmp_pullup_cut(cmp_pullup_cut), .cmp_output_pin_oe(cmp_output_pin_oe),
    .io_read_value(io_read_value), .io_read_override(io_read_override), .wake(wake));
`default_nettype wire

// ### bench/dcc_top_bench.sv
// bench: register, polarity, pin and interrupt tests of the control block
`timescale 1ns/1ns
`default_nettype none
module dcc_top_bench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, irq, ack;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, dout;
    logic [1:0] raw = 2'h0, dir = 2'h1, pdat = 2'h3, sel, pwr, hys, cut, opin, oe, iov, ior, wk;
    int fails = 0, checks_done = 0, ncyc = 0;
    dcc_top DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
        .cmp_raw(raw), .port_dir_in(dir), .port_data(pdat), .cmp_pin_select(sel),
        .cmp_power_on(pwr), .cmp_hysteresis_on(hys), .cmp_pullup_cut(cut),
        .cmp_output_pin(opin), .cmp_output_pin_oe(oe), .io_read_value(iov),
        .io_read_override(ior), .wake(wk), .irq(irq));
    // clock and hang guard
    always #2 clk = ~clk;
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 3000) begin
            fails++;
            report_and_stop;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t saw %h want %h", $time, s, e);
        end
    endtask
    // one classic cycle, held until ack is seen at an edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_regs;
        bus(1'b0, 5'h00, 32'h0); chk(rdat, 32'h81);
        bus(1'b0, 5'h04, 32'h0); chk(rdat, 32'h81);
        bus(1'b0, 5'h14, 32'h0); chk(rdat, 32'h0);
        chk(sel, 2'h3); chk(hys, 2'h3); chk(pwr, 2'h0);
        $display("regs test done");
    endtask
    task automatic t_pins;
        bus(1'b1, 5'h00, 32'hFF); repeat (4) @(posedge clk);
        bus(1'b0, 5'h00, 32'h0); chk(rdat, 32'hF9);
        chk(oe, 2'h2); chk(pwr, 2'h1); chk(cut, 2'h3);
        bus(1'b1, 5'h00, 32'hC0); raw <= 2'h3; repeat (4) @(posedge clk);
        bus(1'b0, 5'h00, 32'h0); chk(rdat, 32'hD0);
        chk(oe, 2'h3); chk(opin, 2'h1); chk(hys, 2'h2); chk(iov, 2'h2);
        bus(1'b1, 5'h00, 32'h40); chk(oe, 2'h2); chk(ior, 2'h2); chk(cut, 2'h2);
        $display("pins test done");
    endtask
    task automatic t_irq;
        bus(1'b1, 5'h10, 32'h3); bus(1'b1, 5'h0C, 32'h3);
        bus(1'b0, 5'h08, 32'h0); chk(rdat, 32'h0); chk(irq, 1'b0);
        raw <= 2'h0; repeat (4) @(posedge clk); // off channel must stay quiet
        bus(1'b0, 5'h08, 32'h0); chk(rdat, 32'h1); chk(irq, 1'b1); chk(wk, 2'h1);
        bus(1'b1, 5'h0C, 32'h0); chk(irq, 1'b0);
        bus(1'b1, 5'h10, 32'h1); bus(1'b0, 5'h08, 32'h0); chk(rdat, 32'h0);
        $display("irq test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_pins;
        t_irq;
        report_and_stop;
    end
endmodule
`default_nettype wire
